// *** src/byte_array.sv ***
// byte-wide storage array with registered read data
`timescale 1ns/1ns
`default_nettype none

module byte_array (
	input wire logic clk_sys,
	input wire logic reset,
	mem_port_if.store port
);

	// storage cells, no reset: contents survive the protocol reset
	serial_mem_pkg::byte_type cells [0:`SM_DEPTH-1];

	// write port, one byte per strobe
	always_ff @(posedge clk_sys) begin
		if (port.wrEn) begin
			cells[port.wrAddr] <= port.wrData;
		end
	end

	// read port, data a cycle after the address
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			port.rdData <= '0;
		end else begin
			port.rdData <= cells[port.rdAddr];
		end
	end

endmodule : byte_array

`default_nettype wire

// *** src/mem_port_if.sv ***
// bundle between the protocol engine and the byte array
`timescale 1ns/1ns
`default_nettype none

interface mem_port_if;
	logic wrEn; // one-cycle write strobe
	serial_mem_pkg::mem_addr_type wrAddr; // location being written
	serial_mem_pkg::byte_type wrData; // byte being written
	serial_mem_pkg::mem_addr_type rdAddr; // current address
	serial_mem_pkg::byte_type rdData; // registered read data

	modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
	modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : mem_port_if

`default_nettype wire

// *** src/serial_byte_memory_slave.sv ***
// two-wire serial slave in front of an 8192 x 8 byte array
// Overview of operation
// - array holds 8192 individually addressed bytes
// - thirteen-bit address sent as two bytes
// - top three received address bits ignored
// - answer only when select bits match straps
// - floating straps read as logic zero
// - data line only pulled low or released
// - send after scl fall, sample on rise
// - write protect high blocks every array write
// - write protect low allows all writes
// - commit byte at once, no busy time
// - ready for next transfer right after write
// - bytes move one bit at a time
// - address byte: type, select, direction bit
// - address increments per byte, wraps to zero
// - start or stop before eighth bit abandons byte
// - reads continue while master acknowledges
`timescale 1ns/1ns
`default_nettype none

module serial_byte_memory_slave #(
	// device type code, value arbitrary
	parameter logic [3:0] deviceTypeCode = 4'h6
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic [2:0] deviceSelectStraps,
	input wire logic writeProtect,
	output logic sdaOut,
	output logic sdaOe
);

	// raw pins gathered for the common sampling chain
	wire logic [`SM_PIN_COUNT-1:0] pinRaw;
	logic [`SM_PIN_COUNT-1:0] syncA; // first stage, read only by syncB
	logic [`SM_PIN_COUNT-1:0] syncB; // second stage
	logic [`SM_PIN_COUNT-1:0] syncC; // third stage
	logic [`SM_PIN_COUNT-1:0] pinLevel; // accepted level after agreement
	logic sclPrev; // accepted scl one cycle back
	logic sdaPrev; // accepted sda one cycle back

	// protocol state
	serial_mem_pkg::state_type state;
	serial_mem_pkg::state_type next_state;
	logic [3:0] bitCount; // rising scl edges seen in the current byte frame
	serial_mem_pkg::byte_type shiftReg; // incoming bits, msb first
	serial_mem_pkg::byte_type txShift; // outgoing bits, msb first
	logic ackPending; // acknowledge owed for the byte just taken
	logic [`SM_HI_ADDR_MSB:0] addrHigh; // live part of the first address byte
	serial_mem_pkg::mem_addr_type addrLatch; // current address

	// port to the storage array
	mem_port_if memPort ();

	assign pinRaw = {writeProtect, deviceSelectStraps, sdaIn, scl};
	// reset the chain to the idle bus levels so release makes no false edge
	wire logic [`SM_PIN_COUNT-1:0] pinIdle;
	assign pinIdle = `SM_PIN_IDLE;

	// three-flop chain per pin; a level counts once stages two and three agree
	generate
		for (genvar i = 0; i < `SM_PIN_COUNT; i++) begin : gSync
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					syncA[i] <= pinIdle[i];
					syncB[i] <= pinIdle[i];
					syncC[i] <= pinIdle[i];
					pinLevel[i] <= pinIdle[i];
				end else begin
					syncA[i] <= pinRaw[i];
					syncB[i] <= syncA[i];
					syncC[i] <= syncB[i];
					if (syncB[i] == syncC[i]) begin
						pinLevel[i] <= syncC[i];
					end
				end
			end
		end
	endgenerate

	// named views of the accepted pin levels
	wire logic sclLevel;
	wire logic sdaLevel;
	wire logic [2:0] selLevel;
	wire logic wpLevel;
	assign sclLevel = pinLevel[`SM_PIN_SCL];
	assign sdaLevel = pinLevel[`SM_PIN_SDA];
	// an open strap is pulled down on the board side, so a low here means zero
	assign selLevel = pinLevel[`SM_PIN_SEL_MSB:`SM_PIN_SEL_LSB];
	// an open write protect pin likewise reads low and leaves writes enabled
	assign wpLevel = pinLevel[`SM_PIN_WP];

	// previous levels for edge detection
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= sclLevel;
			sdaPrev <= sdaLevel;
		end
	end

	// edges and bus conditions, all on synchronised levels
	wire logic sclRise;
	wire logic sclFall;
	wire logic startCond;
	wire logic stopCond;
	assign sclRise = sclLevel & ~sclPrev;
	assign sclFall = ~sclLevel & sclPrev;
	// sda moving while scl stays high marks start or stop
	assign startCond = sclLevel & sclPrev & sdaPrev & ~sdaLevel;
	assign stopCond = sclLevel & sclPrev & ~sdaPrev & sdaLevel;

	// frame decoding
	wire logic active;
	wire logic inRead;
	wire logic byteDone;
	wire logic ackRise;
	wire logic ackFall;
	wire logic endAck;
	wire logic txFall;
	wire logic masterNack;
	wire logic addrMatch;
	wire serial_mem_pkg::byte_type rxByte;
	assign active = (state != serial_mem_pkg::stIdle);
	assign inRead = (state == serial_mem_pkg::stRead);
	// byte assembled with the bit arriving on this rising edge
	assign rxByte = {shiftReg[`SM_BYTE_BITS-2:0], sdaLevel};
	// eighth rising edge of a byte
	assign byteDone = sclRise & active & (bitCount == `SM_LAST_DATA_COUNT);
	assign ackRise = sclRise & active & (bitCount == `SM_ACK_COUNT);
	assign ackFall = sclFall & active & (bitCount == `SM_ACK_COUNT);
	assign endAck = sclFall & active & (bitCount == `SM_ACK_DONE_COUNT);
	// falling edges inside a byte that carry the next outgoing bit
	assign txFall = sclFall & inRead & (bitCount != `SM_COUNT_RESET)
		& (bitCount < `SM_ACK_COUNT);
	// master left the line high in the acknowledge slot of a read byte
	assign masterNack = ackRise & inRead & sdaLevel;
	// type code and select bits must both agree
	assign addrMatch = (rxByte[`SM_TYPE_MSB:`SM_TYPE_LSB] == deviceTypeCode)
		& (rxByte[`SM_SEL_MSB:`SM_SEL_LSB] == selLevel);

	// phase that follows a completed byte
	always_comb begin
		next_state = state;
		unique case (state)
			serial_mem_pkg::stIdle: begin
				next_state = serial_mem_pkg::stIdle;
			end
			serial_mem_pkg::stSlaveAddr: begin
				// a foreign address parks the slave until the next start
				if (!addrMatch) begin
					next_state = serial_mem_pkg::stIdle;
				end else if (rxByte[`SM_RW_BIT]) begin
					next_state = serial_mem_pkg::stRead;
				end else begin
					next_state = serial_mem_pkg::stAddrHigh;
				end
			end
			serial_mem_pkg::stAddrHigh: begin
				next_state = serial_mem_pkg::stAddrLow;
			end
			serial_mem_pkg::stAddrLow: begin
				next_state = serial_mem_pkg::stWrite;
			end
			serial_mem_pkg::stWrite: begin
				next_state = serial_mem_pkg::stWrite;
			end
			serial_mem_pkg::stRead: begin
				next_state = serial_mem_pkg::stRead;
			end
			default: begin
				next_state = serial_mem_pkg::stIdle;
			end
		endcase
	end

	// phase and bit counter; start and stop override everything
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= serial_mem_pkg::stIdle;
			bitCount <= `SM_COUNT_RESET;
		end else if (startCond) begin
			// a start abandons any partial byte and rearms the slave
			state <= serial_mem_pkg::stSlaveAddr;
			bitCount <= `SM_COUNT_RESET;
		end else if (stopCond) begin
			state <= serial_mem_pkg::stIdle;
			bitCount <= `SM_COUNT_RESET;
		end else begin
			if (byteDone) begin
				state <= next_state;
			end
			if (masterNack) begin
				state <= serial_mem_pkg::stIdle;
			end
			if (endAck) begin
				bitCount <= `SM_COUNT_RESET;
			end else if (sclRise && active && bitCount < `SM_ACK_DONE_COUNT) begin
				bitCount <= bitCount + `SM_COUNT_STEP;
			end
		end
	end

	// incoming shift register and acknowledge decision
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			shiftReg <= '0;
			ackPending <= 1'b0;
		end else begin
			if (sclRise && active && bitCount < `SM_ACK_COUNT) begin
				shiftReg <= rxByte;
			end
			// ack every byte the slave receives once it is addressed
			if (byteDone) begin
				ackPending <= !inRead
					&& (state != serial_mem_pkg::stSlaveAddr || addrMatch);
			end
		end
	end

	// data line driver: only ever pulls low, release means high via pull-up
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sdaOe <= 1'b0;
			sdaOut <= 1'b0;
			txShift <= '0;
		end else begin
			sdaOut <= 1'b0;
			if (startCond || stopCond) begin
				sdaOe <= 1'b0;
			end else if (ackFall) begin
				// drive ack for received bytes, let go for the master's ack
				sdaOe <= ackPending;
			end else if (endAck) begin
				// first bit of the next read byte goes out on this fall
				txShift <= memPort.rdData;
				sdaOe <= inRead & ~memPort.rdData[`SM_BYTE_BITS-1];
			end else if (txFall) begin
				sdaOe <= ~txShift[`SM_BYTE_BITS-2];
				txShift <= {txShift[`SM_BYTE_BITS-2:0], 1'b0};
			end
		end
	end

	// address latch and array writes; the write happens on the eighth bit,
	// well inside one scl period, so the next transfer never waits
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			addrHigh <= `SM_HI_ADDR_RESET;
			addrLatch <= `SM_ADDR_RESET;
			memPort.wrEn <= 1'b0;
			memPort.wrAddr <= `SM_ADDR_RESET;
			memPort.wrData <= '0;
		end else begin
			memPort.wrEn <= 1'b0;
			if (byteDone && !startCond && !stopCond) begin
				unique case (state)
					serial_mem_pkg::stAddrHigh: begin
						addrHigh <= rxByte[`SM_HI_ADDR_MSB:0];
					end
					serial_mem_pkg::stAddrLow: begin
						addrLatch <= {addrHigh, rxByte};
					end
					serial_mem_pkg::stWrite: begin
						memPort.wrEn <= ~wpLevel;
						memPort.wrAddr <= addrLatch;
						memPort.wrData <= rxByte;
						addrLatch <= serial_mem_pkg::nextAddress(addrLatch);
					end
					serial_mem_pkg::stRead: begin
						addrLatch <= serial_mem_pkg::nextAddress(addrLatch);
					end
					default: begin
						addrLatch <= addrLatch;
					end
				endcase
			end
		end
	end

	// reads always come from the current address
	assign memPort.rdAddr = addrLatch;

	// the storage array itself
	byte_array array (
		.clk_sys(clk_sys),
		.reset(reset),
		.port(memPort.store)
	);

endmodule : serial_byte_memory_slave

`default_nettype wire

// *** src/serial_mem_pkg.sv ***
// types shared by the serial byte memory slave and its array
`include "serial_mem_regs.svh"

package serial_mem_pkg;

	// protocol phase of the slave
	typedef enum logic [2:0] {
		stIdle,
		stSlaveAddr,
		stAddrHigh,
		stAddrLow,
		stWrite,
		stRead
	} state_type;

	typedef logic [`SM_ADDR_BITS-1:0] mem_addr_type;
	typedef logic [`SM_BYTE_BITS-1:0] byte_type;

	// next sequential address, rolls over from the top to zero
	function automatic mem_addr_type nextAddress(input mem_addr_type addr);
		nextAddress = addr + `SM_ADDR_STEP;
	endfunction : nextAddress

endpackage : serial_mem_pkg

// *** src/serial_mem_regs.svh ***
// constants for the serial byte memory slave: widths, field positions, counts
`ifndef SERIAL_MEM_REGS_SVH
`define SERIAL_MEM_REGS_SVH

// array geometry
`define SM_ADDR_BITS 13
`define SM_DEPTH 8192
`define SM_BYTE_BITS 8
`define SM_ADDR_RESET 13'h0000
`define SM_ADDR_STEP 13'h0001

// memory address: upper byte carries five live bits, three ignored
`define SM_HI_ADDR_MSB 4
`define SM_HI_ADDR_RESET 5'h00

// slave address byte fields
`define SM_TYPE_MSB 7
`define SM_TYPE_LSB 4
`define SM_SEL_MSB 3
`define SM_SEL_LSB 1
`define SM_RW_BIT 0

// bit counter values within one byte frame
`define SM_LAST_DATA_COUNT 4'h7
`define SM_ACK_COUNT 4'h8
`define SM_ACK_DONE_COUNT 4'h9
`define SM_COUNT_RESET 4'h0
`define SM_COUNT_STEP 4'h1

// pin sampling: scl, sda, three straps, write protect
`define SM_PIN_COUNT 6
`define SM_PIN_SCL 0
`define SM_PIN_SDA 1
`define SM_PIN_SEL_LSB 2
`define SM_PIN_SEL_MSB 4
`define SM_PIN_WP 5
// idle levels of the sampled pins: both bus wires float high
`define SM_PIN_IDLE 6'h03

`endif

// *** tb/i2c_master_model.sv ***
// two-wire bus master: makes the clock and pulls the data wire
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
	input wire logic clk_sys,
	input wire logic sda,
	output logic scl,
	output logic mOe
);
	// clock stands high and wire released between frames
	initial begin
		scl = 1'b1;
		mOe = 1'b0;
	end
	// one bit: long low phase, since the slave answers about 45 ns after a fall
	task automatic bitx(input logic b, output logic r);
		#20 mOe = ~b;
		#30 scl = 1'b1;
		#20 r = sda;
		#10 scl = 1'b0;
	endtask : bitx
	// eight bits msb first, then the acknowledge slot
	task automatic xfer(input serial_mem_pkg::byte_type d, input logic ackIn,
		output serial_mem_pkg::byte_type q, output logic ackOut);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(ackIn, ackOut);
	endtask : xfer
	// start, also repeated start from a low clock
	task automatic start();
		#20 mOe = 1'b0;
		#30 scl = 1'b1;
		#20 mOe = 1'b1;
		#30 scl = 1'b0;
	endtask : start
	// stop leaves the bus idle
	task automatic stop();
		#20 mOe = 1'b1;
		#30 scl = 1'b1;
		#20 mOe = 1'b0;
		#30;
	endtask : stop
endmodule : i2c_master_model
`default_nettype wire

// *** tb/serial_mem_asserts.sv ***
// concurrent checks on the pins of the serial byte memory slave
`timescale 1ns/1ns
`default_nettype none
module serial_mem_asserts (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic [2:0] deviceSelectStraps,
	input wire logic writeProtect,
	input wire logic sdaOut,
	input wire logic sdaOe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	logic [6:0] oeRun; // cycles the wire has been pulled low
	// run length of the pull, cleared on release
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			oeRun <= 7'h00;
		end else if (sdaOe) begin
			oeRun <= oeRun + 7'h01;
		end else begin
			oeRun <= 7'h00;
		end
	end
	// start: data falls while the clock pin stays high
	sequence startSeen;
		scl && $past(scl) && $fell(sdaIn);
	endsequence
	a_out_never_high: assert property (sdaOut == 1'b0)
		else $error("data output driven high");
	a_reset_quiet: assert property (disable iff (1'b0) reset |=> !sdaOe)
		else $error("data line pulled during reset");
	a_change_scl_low: assert property ($changed(sdaOe) |-> !$past(scl) && !$past(scl, 4))
		else $error("data output changed outside clock low");
	a_drive_hold: assert property ($rose(sdaOe) |-> sdaOe [*6])
		else $error("low bit not held");
	a_release_hold: assert property ($fell(sdaOe) |-> !sdaOe [*6])
		else $error("released bit not held");
	a_run_bound: assert property (oeRun < 7'h5a)
		else $error("data line held low too long");
	a_addr_silent: assert property (startSeen |-> !sdaOe throughout (##60 1'b1))
		else $error("pulled before address byte ended");
	a_idle_quiet: assert property (scl [*8] |-> !sdaOe)
		else $error("data line pulled on idle bus");
	c_start: cover property (startSeen);
	c_pull: cover property ($rose(sdaOe));
	c_release: cover property ($fell(sdaOe) && !scl);
endmodule : serial_mem_asserts
`default_nettype wire

// *** tb/tb_top.sv ***
// bench: random and corner traffic through the master model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam logic [3:0] typeCode = 4'h6; // arbitrary type code
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic writeProtect = 1'b0;
	logic [2:0] straps = 3'h0; // open straps read low
	logic sdaOut, sdaOe, mOe, scl, ak;
	wire logic sda;
	serial_mem_pkg::byte_type q;
	serial_mem_pkg::byte_type refMem [int]; // expected contents
	int bad_count = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'h8;
	logic [12:0] a;
	assign sda = ~(sdaOe | mOe);
	always #5 clk_sys = ~clk_sys;
	serial_byte_memory_slave #(.deviceTypeCode(typeCode)) dut (.clk_sys(clk_sys),
		.reset(reset), .scl(scl), .sdaIn(sda), .deviceSelectStraps(straps),
		.writeProtect(writeProtect), .sdaOut(sdaOut), .sdaOe(sdaOe));
	i2c_master_model m (.clk_sys(clk_sys), .sda(sda), .scl(scl), .mOe(mOe));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// expected location, wraps past the top
	function automatic logic [12:0] loc(input logic [12:0] b, input int i);
		return b + 13'(i);
	endfunction : loc
	task automatic chkBit(input string what, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", what, e, g);
		end
	endtask : chkBit
	task automatic chkByte(input string what, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chkByte
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic slaveAddr(input logic rw);
		m.start();
		m.xfer({typeCode, straps, rw}, 1'b1, q, ak);
		chkBit("select ack", 1'b0, ak);
	endtask : slaveAddr
	// ignored top bits of the high byte are random
	task automatic setAddr(input logic [12:0] b);
		logic [7:0] h;
		h = 8'(rnd());
		slaveAddr(1'b0);
		m.xfer({h[2:0], b[12:8]}, 1'b1, q, ak);
		chkBit("addr high ack", 1'b0, ak);
		m.xfer(b[7:0], 1'b1, q, ak);
		chkBit("addr low ack", 1'b0, ak);
	endtask : setAddr
	task automatic wrData(input logic [12:0] b, input int n);
		logic [7:0] d;
		setAddr(b);
		for (int i = 0; i < n; i++) begin
			d = 8'(rnd());
			m.xfer(d, 1'b1, q, ak);
			chkBit("data ack", 1'b0, ak);
			if (!writeProtect) refMem[loc(b, i)] = d;
		end
		m.stop();
	endtask : wrData
	// cur set: no address phase, read from the current address
	task automatic rdData(input logic [12:0] b, input int n, input logic cur);
		if (!cur) setAddr(b);
		slaveAddr(1'b1);
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hff, i == n - 1, q, ak);
			if (refMem.exists(loc(b, i))) chkByte("read data", refMem[loc(b, i)], q);
		end
		m.stop();
	endtask : rdData
	initial begin
		repeat (10) @(negedge clk_sys);
		reset = 1'b0;
		repeat (10) @(negedge clk_sys);
		// every select value against tied-low straps
		for (int i = 0; i < 8; i++) begin
			m.start();
			m.xfer({typeCode, 3'(i), 1'b0}, 1'b1, q, ak);
			chkBit("select ack", 3'(i) != straps, ak);
			m.stop();
		end
		m.start();
		m.xfer({~typeCode, straps, 1'b0}, 1'b1, q, ak);
		chkBit("type ack", 1'b1, ak);
		m.stop();
		wrData(13'h1fff, 3);
		rdData(13'h1fff, 3, 1'b0);
		// protected rewrite must leave the first data in place
		for (int k = 0; k < 6; k++) begin
			straps = 3'(rnd());
			a = 13'(rnd());
			wrData(a, 6);
			writeProtect = 1'b1;
			wrData(a, 6);
			writeProtect = 1'b0;
			rdData(a, 3, 1'b0);
			rdData(loc(a, 3), 3, 1'b1);
		end
		// stop after four data bits abandons the byte
		setAddr(a);
		repeat (4) m.bitx(1'b0, ak);
		m.stop();
		rdData(a, 1, 1'b0);
		// contents survive a reset in mid-run
		reset = 1'b1;
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		repeat (10) @(negedge clk_sys);
		rdData(a, 2, 1'b0);
		give_verdict();
	end
	// hang guard
	initial begin
		#900000;
		bad_count++;
		give_verdict();
	end
endmodule : tb_top
bind serial_byte_memory_slave serial_mem_asserts chk (.clk_sys(clk_sys), .reset(reset),
	.scl(scl), .sdaIn(sdaIn), .deviceSelectStraps(deviceSelectStraps),
	.writeProtect(writeProtect), .sdaOut(sdaOut), .sdaOe(sdaOe));
`default_nettype wire
